/* include/eep_pkg.sv */
package eep_pkg;

   // Bench clock and the internal programming time
   localparam int unsigned CLK_PERIOD_NS       = 50;
   localparam int unsigned WRITE_CYCLE_TIME_NS = 5000000;
   // Longest time, so the count rounds down
   localparam int unsigned WRITE_CYCLE_CLKS    = WRITE_CYCLE_TIME_NS / CLK_PERIOD_NS;
   // Fastest serial clock the edge detector is sized for
   localparam int unsigned SCL_MAX_KHZ         = 1000;

   localparam int unsigned ADDR_W      = 16;
   localparam int unsigned MEM_BYTES   = 65536;
   localparam int unsigned PAGE_W      = 7;
   localparam int unsigned PAGE_DEPTH  = 128;
   localparam logic [7:0]  PAGE_BYTES  = 8'h80;
   localparam logic [3:0]  BYTE_BITS   = 4'h8;

   // Select code layout
   localparam logic [3:0]  TYPE_ARRAY  = 4'ha;
   localparam logic [3:0]  TYPE_IDPAGE = 4'hb;
   localparam int unsigned SEL_TYPE_LSB = 4;
   localparam int unsigned SEL_CS_LSB   = 1;
   localparam int unsigned SEL_RW_BIT   = 0;

   // Identification page lock request
   localparam int unsigned LOCK_ADDR_BIT = 10;
   localparam int unsigned LOCK_DATA_BIT = 1;

   // Synchroniser reset image: serial lines idle high, straps low
   localparam logic [5:0]  SYNC_RESET = 6'h03;

   typedef struct packed {
      logic [6:0] off;
      logic [7:0] data;
   } eep_wr_item_type;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_DEV  = 7'h02,
      ST_AHI  = 7'h04,
      ST_ALO  = 7'h08,
      ST_WR   = 7'h10,
      ST_RD   = 7'h20,
      ST_WAIT = 7'h40
   } eep_state_type;

endpackage : eep_pkg

/* src/eep_pair_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module eep_pair_fifo (
   input  wire logic                     clk_in,
   input  wire logic                     resetn_in,
   input  wire logic                     in_valid_in,
   input  wire eep_pkg::eep_wr_item_type in_item_in,
   output logic                          in_ready_out,
   output logic                          out_valid_out,
   output eep_pkg::eep_wr_item_type      out_item_out,
   input  wire logic                     out_ready_in
);
   eep_pkg::eep_wr_item_type slot_q [2];
   eep_pkg::eep_wr_item_type slot_d [2];
   logic       wr_q;
   logic       wr_d;
   logic       rd_q;
   logic       rd_d;
   logic [1:0] cnt_q;
   logic [1:0] cnt_d;
   logic       push;
   logic       pop;

   always_comb begin
      in_ready_out  = (cnt_q != 2'h2);
      out_valid_out = (cnt_q != 2'h0);
      out_item_out  = slot_q[rd_q];
      push          = in_valid_in & in_ready_out;
      pop           = out_valid_out & out_ready_in;
      slot_d        = slot_q;
      wr_d          = wr_q;
      rd_d          = rd_q;
      cnt_d         = cnt_q;
      if (push) begin
         slot_d[wr_q] = in_item_in;
         wr_d         = ~wr_q;
      end
      if (pop) begin
         rd_d = ~rd_q;
      end
      if (push & ~pop) begin
         cnt_d = cnt_q + 2'h1;
      end else if (pop & ~push) begin
         cnt_d = cnt_q - 2'h1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         slot_q[0] <= '0;
         slot_q[1] <= '0;
         wr_q      <= 1'b0;
         rd_q      <= 1'b0;
         cnt_q     <= 2'h0;
      end else begin
         slot_q <= slot_d;
         wr_q   <= wr_d;
         rd_q   <= rd_d;
         cnt_q  <= cnt_d;
      end
   end
endmodule : eep_pair_fifo
`default_nettype wire

/* src/eep_slave.sv */
`timescale 1ns/10ps
`default_nettype none
module eep_slave #(
   parameter int unsigned WRITE_CYCLES = eep_pkg::WRITE_CYCLE_CLKS
) (
   input  wire logic clk_in,
   input  wire logic resetn_in,
   input  wire logic scl_in,
   input  wire logic sda_in,
   input  wire logic chip_select_strap_hi_in,
   input  wire logic chip_select_strap_mid_in,
   input  wire logic chip_select_strap_lo_in,
   input  wire logic write_protect_input_in,
   output logic      sda_out,
   output logic      sda_oe_out,
   output logic      write_busy_out,
   output logic      id_locked_out
);
   localparam int unsigned TW = $clog2(WRITE_CYCLES + 1);

   function automatic logic [15:0] addr_inc(input logic [15:0] a, input logic in_page);
      logic [15:0] r;
      r = a + 16'h0001;
      if (in_page) begin
         r = {a[15:7], r[6:0]};
      end
      return r;
   endfunction : addr_inc

   // Synchronisers and edge history
   logic [5:0] meta_q;
   logic [5:0] sync_q;
   logic       scl_prev_q;
   logic       sda_prev_q;
   logic       scl_s;
   logic       sda_s;
   logic [2:0] cs_s;
   logic       wp_s;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_ev;
   logic       stop_ev;

   // Protocol state
   eep_pkg::eep_state_type st_q;
   eep_pkg::eep_state_type st_d;
   logic [3:0]  cnt_q;
   logic [3:0]  cnt_d;
   logic        ack_q;
   logic        ack_d;
   logic [7:0]  shift_q;
   logic [7:0]  shift_d;
   logic        oe_q;
   logic        oe_d;
   logic [15:0] addr_q;
   logic [15:0] addr_d;
   logic [8:0]  page_q;
   logic [8:0]  page_d;
   logic        idsel_q;
   logic        idsel_d;
   logic        pend_q;
   logic        pend_d;

   // Write cycle state
   logic          busy_q;
   logic          busy_d;
   logic [TW-1:0] timer_q;
   logic [TW-1:0] timer_d;
   logic [7:0]    commit_q;
   logic [7:0]    commit_d;
   logic          lock_q;
   logic          lock_d;
   logic          lock_req_q;
   logic          lock_req_d;
   logic [7:0]    pbuf_q [eep_pkg::PAGE_DEPTH];
   logic [7:0]    pbuf_d [eep_pkg::PAGE_DEPTH];
   logic [eep_pkg::PAGE_DEPTH-1:0] pmask_q;
   logic [eep_pkg::PAGE_DEPTH-1:0] pmask_d;

   // Storage, not reset: its contents survive a reset
   logic [7:0]  mem_q [eep_pkg::MEM_BYTES];
   logic [7:0]  idpg_q [eep_pkg::PAGE_DEPTH];
   logic        mem_we;
   logic        idpg_we;
   logic [15:0] mem_waddr;
   logic [7:0]  mem_wdata;
   logic [7:0]  rd_byte;

   // Data buffer between receiver and page buffer
   logic                     push_valid;
   eep_pkg::eep_wr_item_type push_item;
   logic                     push_ready;
   logic                     pop_valid;
   eep_pkg::eep_wr_item_type pop_item;
   logic                     pop_ready;

   // Pins are sampled at 20 MHz, ample for a 1 MHz serial clock
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         meta_q     <= eep_pkg::SYNC_RESET;
         sync_q     <= eep_pkg::SYNC_RESET;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
         sda_out    <= 1'b0;
      end else begin
         meta_q     <= {write_protect_input_in, chip_select_strap_hi_in,
                        chip_select_strap_mid_in, chip_select_strap_lo_in, sda_in, scl_in};
         sync_q     <= meta_q;
         scl_prev_q <= sync_q[0];
         sda_prev_q <= sync_q[1];
         sda_out    <= 1'b0; // Never driven high, only pulled low
      end
   end

   always_comb begin
      scl_s    = sync_q[0];
      sda_s    = sync_q[1];
      cs_s     = sync_q[4:2]; // Pads pull down, so a floating strap is 0
      wp_s     = sync_q[5];
      scl_rise = scl_s & ~scl_prev_q;
      scl_fall = ~scl_s & scl_prev_q;
      start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
      stop_ev  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
   end

   always_comb begin
      rd_byte   = idsel_q ? idpg_q[addr_q[6:0]] : mem_q[addr_q];
      mem_wdata = pbuf_q[commit_q[6:0]];
      mem_waddr = {page_q, commit_q[6:0]};
      mem_we    = busy_q & (commit_q < eep_pkg::PAGE_BYTES) & pmask_q[commit_q[6:0]] & ~idsel_q;
      idpg_we   = busy_q & (commit_q < eep_pkg::PAGE_BYTES) & pmask_q[commit_q[6:0]] & idsel_q;
      pop_ready = ~busy_q;
   end

   eep_pair_fifo u_fifo (
      .clk_in        (clk_in),
      .resetn_in     (resetn_in),
      .in_valid_in   (push_valid),
      .in_item_in    (push_item),
      .in_ready_out  (push_ready),
      .out_valid_out (pop_valid),
      .out_item_out  (pop_item),
      .out_ready_in  (pop_ready)
   );

   always_comb begin
      st_d       = st_q;
      cnt_d      = cnt_q;
      ack_d      = ack_q;
      shift_d    = shift_q;
      oe_d       = oe_q;
      addr_d     = addr_q;
      page_d     = page_q;
      idsel_d    = idsel_q;
      pend_d     = pend_q;
      busy_d     = busy_q;
      timer_d    = timer_q;
      commit_d   = commit_q;
      lock_d     = lock_q;
      lock_req_d = lock_req_q;
      pbuf_d     = pbuf_q;
      pmask_d    = pmask_q;
      push_valid = 1'b0;
      push_item  = '{off: addr_q[6:0], data: shift_q};
      if (pop_valid & pop_ready) begin
         pbuf_d[pop_item.off]  = pop_item.data;
         pmask_d[pop_item.off] = 1'b1;
      end
      if (busy_q) begin
         // Bus ignored while programming; master polls for select ack
         st_d    = eep_pkg::ST_IDLE;
         oe_d    = 1'b0;
         timer_d = timer_q - 1'b1;
         if (commit_q < eep_pkg::PAGE_BYTES) begin
            commit_d = commit_q + 8'h01;
         end
         if (timer_q == TW'(1)) begin
            busy_d  = 1'b0; // Cycle done, back to standby
            pmask_d = '0;
            pend_d  = 1'b0;
            if (lock_req_q) begin
               lock_d     = 1'b1; // Only reset clears the lock
               lock_req_d = 1'b0;
            end
         end
      end else if (start_ev) begin
         st_d       = eep_pkg::ST_DEV;
         cnt_d      = 4'h0;
         ack_d      = 1'b0;
         oe_d       = 1'b0;
         pend_d     = 1'b0;
         pmask_d    = '0;
         lock_req_d = 1'b0;
      end else if (stop_ev) begin
         st_d = eep_pkg::ST_IDLE; // Standby
         oe_d = 1'b0;
         ack_d = 1'b0;
         // Stop inside the slot right after a data ack, one bit already clocked
         if ((st_q == eep_pkg::ST_WR) && (cnt_q == 4'h1) && !ack_q && pend_q) begin
            busy_d   = 1'b1;
            timer_d  = TW'(WRITE_CYCLES);
            commit_d = 8'h00;
         end else begin
            pend_d     = 1'b0;
            pmask_d    = '0;
            lock_req_d = 1'b0;
         end
      end else begin
         case (st_q)
            eep_pkg::ST_DEV, eep_pkg::ST_AHI, eep_pkg::ST_ALO, eep_pkg::ST_WR: begin
               if (scl_rise && !ack_q && (cnt_q < eep_pkg::BYTE_BITS)) begin
                  shift_d = {shift_q[6:0], sda_s}; // Sampled on the clock's rise
                  cnt_d   = cnt_q + 4'h1;
               end else if (scl_fall && !ack_q && (cnt_q == eep_pkg::BYTE_BITS)) begin
                  ack_d = 1'b1;
                  case (st_q)
                     eep_pkg::ST_DEV: begin
                        // Type field picks array or ID page
                        if (((shift_q[7:4] == eep_pkg::TYPE_ARRAY) ||
                             (shift_q[7:4] == eep_pkg::TYPE_IDPAGE)) &&
                            (shift_q[3:1] == cs_s)) begin
                           oe_d    = 1'b1;
                           idsel_d = shift_q[eep_pkg::SEL_TYPE_LSB];
                        end else begin
                           st_d  = eep_pkg::ST_WAIT; // Line stays released
                           ack_d = 1'b0;
                        end
                     end
                     eep_pkg::ST_AHI: begin
                        oe_d         = 1'b1; // Acked even when protected
                        addr_d[15:8] = shift_q;
                     end
                     eep_pkg::ST_ALO: begin
                        oe_d        = 1'b1;
                        addr_d[7:0] = shift_q;
                     end
                     default: begin
                        // Protected or locked data is refused with no ack
                        if (!wp_s && !(idsel_q && lock_q)) begin
                           if (idsel_q && addr_q[eep_pkg::LOCK_ADDR_BIT]) begin
                              oe_d       = 1'b1;
                              pend_d     = 1'b1;
                              lock_req_d = shift_q[eep_pkg::LOCK_DATA_BIT];
                           end else if (push_ready) begin
                              // A full buffer refuses the byte rather than lose it
                              push_valid = 1'b1;
                              oe_d       = 1'b1;
                              pend_d     = 1'b1;
                              addr_d     = addr_inc(addr_q, 1'b1); // Wraps in page
                           end
                        end
                     end
                  endcase
               end else if (scl_fall && ack_q) begin
                  ack_d = 1'b0;
                  cnt_d = 4'h0;
                  oe_d  = 1'b0;
                  case (st_q)
                     eep_pkg::ST_DEV: begin
                        if (shift_q[eep_pkg::SEL_RW_BIT]) begin
                           // Read from current address, first bit out now
                           st_d    = eep_pkg::ST_RD;
                           shift_d = rd_byte;
                           oe_d    = ~rd_byte[7];
                           cnt_d   = 4'h1;
                        end else begin
                           st_d = eep_pkg::ST_AHI;
                        end
                     end
                     eep_pkg::ST_AHI: st_d = eep_pkg::ST_ALO;
                     eep_pkg::ST_ALO: begin
                        st_d   = eep_pkg::ST_WR;
                        page_d = addr_q[15:7];
                     end
                     default: st_d = eep_pkg::ST_WR;
                  endcase
               end
            end
            eep_pkg::ST_RD: begin
               if (scl_fall && !ack_q && (cnt_q < eep_pkg::BYTE_BITS)) begin
                  oe_d    = ~shift_q[6]; // Pull low for a 0, release for a 1
                  shift_d = {shift_q[6:0], 1'b0};
                  cnt_d   = cnt_q + 4'h1;
               end else if (scl_fall && !ack_q && (cnt_q == eep_pkg::BYTE_BITS)) begin
                  oe_d   = 1'b0;
                  ack_d  = 1'b1;
                  addr_d = addr_inc(addr_q, idsel_q); // Sequential read
               end else if (scl_rise && ack_q && sda_s) begin
                  st_d  = eep_pkg::ST_WAIT;
                  ack_d = 1'b0;
               end else if (scl_fall && ack_q) begin
                  ack_d   = 1'b0;
                  shift_d = rd_byte;
                  oe_d    = ~rd_byte[7];
                  cnt_d   = 4'h1;
               end
            end
            eep_pkg::ST_IDLE, eep_pkg::ST_WAIT: begin
               oe_d = 1'b0;
            end
            default: begin
               st_d = eep_pkg::ST_IDLE;
               oe_d = 1'b0;
            end
         endcase
      end
   end

   // Reset holds the slave deaf and released; release lands in standby
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         st_q       <= eep_pkg::ST_IDLE;
         cnt_q      <= 4'h0;
         ack_q      <= 1'b0;
         shift_q    <= 8'h00;
         oe_q       <= 1'b0;
         addr_q     <= 16'h0000;
         page_q     <= 9'h000;
         idsel_q    <= 1'b0;
         pend_q     <= 1'b0;
         busy_q     <= 1'b0;
         timer_q    <= '0;
         commit_q   <= 8'h00;
         lock_q     <= 1'b0;
         lock_req_q <= 1'b0;
         pmask_q    <= '0;
      end else begin
         st_q       <= st_d;
         cnt_q      <= cnt_d;
         ack_q      <= ack_d;
         shift_q    <= shift_d;
         oe_q       <= oe_d;
         addr_q     <= addr_d;
         page_q     <= page_d;
         idsel_q    <= idsel_d;
         pend_q     <= pend_d;
         busy_q     <= busy_d;
         timer_q    <= timer_d;
         commit_q   <= commit_d;
         lock_q     <= lock_d;
         lock_req_q <= lock_req_d;
         pmask_q    <= pmask_d;
      end
   end

   // Page buffer holds data only; its valid mask is reset above
   always_ff @(posedge clk_in) begin
      pbuf_q <= pbuf_d;
   end

   always_ff @(posedge clk_in) begin
      if (mem_we) begin
         mem_q[mem_waddr] <= mem_wdata;
      end
      if (idpg_we) begin
         idpg_q[mem_waddr[6:0]] <= mem_wdata;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         sda_oe_out     <= 1'b0;
         write_busy_out <= 1'b0;
         id_locked_out  <= 1'b0;
      end else begin
         sda_oe_out     <= oe_d;
         write_busy_out <= busy_d;
         id_locked_out  <= lock_d;
      end
   end
endmodule : eep_slave
`default_nettype wire

/* verification/eep_slave_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module eep_slave_sva #(
   parameter int unsigned WRITE_CYCLES = 200
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic chip_select_strap_hi_in,
   input wire logic chip_select_strap_mid_in,
   input wire logic chip_select_strap_lo_in,
   input wire logic write_protect_input_in,
   input wire logic sda_out,
   input wire logic sda_oe_out,
   input wire logic write_busy_out,
   input wire logic id_locked_out
);
   int unsigned busy_cnt_d;
   int unsigned busy_cnt_q;

   // Length of the current write cycle, zero outside it
   always_comb begin
      busy_cnt_d = (resetn_in && write_busy_out) ? busy_cnt_q + 1 : 0;
   end
   always_ff @(posedge clk_in) begin
      busy_cnt_q <= busy_cnt_d;
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   sequence s_quiet3;
      !sda_oe_out [*3];
   endsequence
   property p_open_drain;
      sda_out == 1'b0;
   endproperty
   property p_busy_quiet;
      write_busy_out |-> !sda_oe_out;
   endproperty
   property p_busy_len;
      busy_cnt_q <= WRITE_CYCLES;
   endproperty
   property p_busy_end;
      $fell(write_busy_out) |-> busy_cnt_q >= WRITE_CYCLES;
   endproperty
   property p_busy_start;
      $rose(write_busy_out) |-> scl_in && sda_in;
   endproperty
   // Output moves only in the low phase, ahead of the next rise
   property p_oe_scl_low;
      $changed(sda_oe_out) |-> !scl_in;
   endproperty
   property p_por_quiet;
      $rose(resetn_in) |-> s_quiet3 ##0 (!write_busy_out && !id_locked_out);
   endproperty
   property p_standby;
      $fell(write_busy_out) |-> s_quiet3;
   endproperty
   property p_lock_keep;
      !$fell(id_locked_out);
   endproperty
   property p_lock_rise;
      $rose(id_locked_out) |-> $past(write_busy_out) || $past(write_busy_out, 2);
   endproperty

   a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
   a_busy_quiet: assert property (p_busy_quiet) else $error("pin pulled while busy");
   a_busy_len: assert property (p_busy_len) else $error("write cycle too long");
   a_busy_end: assert property (p_busy_end) else $error("write cycle too short");
   a_busy_start: assert property (p_busy_start) else $error("write without stop");
   a_oe_scl_low: assert property (p_oe_scl_low) else $error("pin moved, clock high");
   a_por_quiet: assert property (p_por_quiet) else $error("active after reset");
   a_standby: assert property (p_standby) else $error("active after write");
   a_lock_keep: assert property (p_lock_keep) else $error("lock dropped");
   a_lock_rise: assert property (p_lock_rise) else $error("lock outside write");
endmodule : eep_slave_sva
`default_nettype wire

/* verification/eep_master_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Bus master: 400 ns bits, 2.5 MHz, above the 1 MHz ceiling
module eep_master_model (
   input  wire logic clk_in,
   input  wire logic sda_in,
   output var  logic scl_out,
   output var  logic sda_pull_out
);
   initial begin
      scl_out      = 1'b1;
      sda_pull_out = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk_in);
   endtask : tick
   // Data moves only while the clock is low
   task automatic bit_io(input logic tx, output logic rx);
      scl_out = 1'b0;
      tick(1);
      sda_pull_out = !tx;
      tick(3);
      scl_out = 1'b1;
      tick(2);
      rx = sda_in;
      tick(2);
   endtask : bit_io
   // Longer low phase so the slave has let go before the clock rises
   task automatic start();
      scl_out = 1'b0;
      tick(1);
      sda_pull_out = 1'b0;
      tick(5);
      scl_out = 1'b1;
      tick(4);
      sda_pull_out = 1'b1;
      tick(4);
   endtask : start
   task automatic stop();
      scl_out = 1'b0;
      tick(1);
      sda_pull_out = 1'b1;
      tick(3);
      scl_out = 1'b1;
      tick(4);
      sda_pull_out = 1'b0;
      tick(4);
   endtask : stop
   task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
   endtask : byte_io
   // Select repeated until acknowledged after a write
   task automatic poll(input logic [7:0] sel, output int tries);
      logic [8:0] rx;
      tries = 0;
      do begin
         start();
         byte_io({sel, 1'b1}, rx);
         stop();
         tries++;
      end while (rx[0] && tries < 40);
   endtask : poll
endmodule : eep_master_model
`default_nettype wire

/* verification/eep_slave_test.sv */
`timescale 1ns/10ps
`default_nettype none
module eep_slave_test;
   localparam int unsigned WRITE_CYCLES = 200;
   localparam logic [3:0]  TA = eep_pkg::TYPE_ARRAY;
   localparam logic [3:0]  TI = eep_pkg::TYPE_IDPAGE;
   logic       clk_in;
   logic       resetn_in;
   logic [2:0] straps;
   logic       wp;
   logic       scl;
   logic       m_pull;
   logic       sda_out;
   logic       sda_oe;
   logic       busy;
   logic       locked;
   wire        sda_line;
   int         failures;
   int         num_checks;
   int         seed;
   logic [7:0] arr[int];
   logic [7:0] idp[int];
   logic       lock_ref;

   // Pull-up wire: low while either side pulls
   assign sda_line = !((sda_oe && !sda_out) || m_pull);

   eep_slave #(.WRITE_CYCLES(WRITE_CYCLES)) i_dut (
      .clk_in(clk_in), .resetn_in(resetn_in), .scl_in(scl), .sda_in(sda_line),
      .chip_select_strap_hi_in(straps[2]), .chip_select_strap_mid_in(straps[1]),
      .chip_select_strap_lo_in(straps[0]), .write_protect_input_in(wp),
      .sda_out(sda_out), .sda_oe_out(sda_oe), .write_busy_out(busy), .id_locked_out(locked));
   eep_master_model i_master (
      .clk_in(clk_in), .sda_in(sda_line), .scl_out(scl), .sda_pull_out(m_pull));

   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = !clk_in;
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict
   function automatic logic [7:0] sel(input logic [3:0] ty, input logic rw);
      return {ty, straps, rw};
   endfunction : sel

   task automatic wr(input logic [3:0] ty, input logic [15:0] a, input int n);
      logic [8:0] rx;
      logic [7:0] d;
      logic       ok;
      int         tries;
      ok = !wp && !(ty == TI && lock_ref);
      i_master.start();
      i_master.byte_io({sel(ty, 1'b0), 1'b1}, rx);
      check("select ack", rx[0], 1'b0);
      i_master.byte_io({a[15:8], 1'b1}, rx);
      check("address ack", rx[0], 1'b0);
      i_master.byte_io({a[7:0], 1'b1}, rx);
      check("address ack", rx[0], 1'b0);
      for (int i = 0; i < n; i++) begin
         d = 8'($random(seed)) | {6'h00, a[10], 1'b0};
         i_master.byte_io({d, 1'b1}, rx);
         check("data ack", rx[0], !ok);
         if (ok && ty == TI && a[10]) lock_ref = 1'b1;
         else if (ok && ty == TI) idp[(int'(a) + i) % 128] = d;
         else if (ok) arr[{a[15:7], 7'(a[6:0] + i)}] = d;
      end
      i_master.stop();
      i_master.poll(sel(ty, 1'b0), tries);
      if (ok) check("busy seen", tries > 1, 1'b1);
      // A poll that gave up leaves busy high, so a stuck write cannot pass
      check("write ended", busy, 1'b0);
      check("lock flag", locked, lock_ref);
   endtask : wr

   task automatic rd(input logic [3:0] ty, input logic [15:0] a, input int n);
      logic [8:0] rx;
      int         k;
      i_master.start();
      i_master.byte_io({sel(ty, 1'b0), 1'b1}, rx);
      i_master.byte_io({a[15:8], 1'b1}, rx);
      i_master.byte_io({a[7:0], 1'b1}, rx);
      i_master.start();
      i_master.byte_io({sel(ty, 1'b1), 1'b1}, rx);
      check("read select ack", rx[0], 1'b0);
      for (int i = 0; i < n; i++) begin
         i_master.byte_io({8'hff, i == n - 1}, rx);
         k = (ty == TI) ? (int'(a) + i) % 128 : (int'(a) + i) % 65536;
         if (ty == TI && idp.exists(k)) check("id byte", rx[8:1], idp[k]);
         if (ty == TA && arr.exists(k)) check("array byte", rx[8:1], arr[k]);
      end
      i_master.stop();
   endtask : rd

   initial begin
      logic [8:0]  rx;
      logic [15:0] a;
      seed = 32'h11c1;
      failures = 0;
      num_checks = 0;
      lock_ref = 1'b0;
      resetn_in = 1'b0;
      straps = 3'h0;
      wp = 1'b0;
      repeat (5) @(negedge clk_in);
      resetn_in = 1'b1;
      repeat (3) @(negedge clk_in);
      // Straps 0 first stands for unconnected inputs
      for (int s = 0; s < 4; s++) begin
         straps = (s == 0) ? 3'h0 : 3'($random(seed));
         for (int c = 0; c < 8; c++) begin
            i_master.start();
            i_master.byte_io({TA, 3'(c), 1'b0, 1'b1}, rx);
            check("select match", rx[0], 3'(c) != straps);
            i_master.byte_io(9'h1ff, rx);
            check("ignored after mismatch", rx[0], 3'(c) != straps);
            i_master.stop();
            check("no write on early stop", busy, 1'b0);
         end
      end
      $display("select test done");
      a = {16'($random(seed)) | 16'h007e} & 16'hfbfe;
      wr(TA, a, 5);
      rd(TA, {a[15:7], 7'h00}, 128);
      $display("page write test done");
      wp = 1'b1;
      wr(TA, {a[15:7], 7'h01}, 2);
      wp = 1'b0;
      rd(TA, {a[15:7], 7'h00}, 4);
      $display("write protect test done");
      wr(TI, 16'h0010, 3);
      rd(TI, 16'h0010, 3);
      wr(TI, 16'h0400, 1);
      wr(TI, 16'h0011, 2);
      rd(TI, 16'h0010, 3);
      $display("id page test done");
      i_master.start();
      i_master.byte_io({sel(TI, 1'b0), 1'b1}, rx);
      resetn_in = 1'b0;
      i_master.start();
      i_master.byte_io({sel(TA, 1'b0), 1'b1}, rx);
      check("no answer in reset", rx[0], 1'b1);
      resetn_in = 1'b1;
      lock_ref = 1'b0;
      repeat (3) @(negedge clk_in);
      check("lock cleared", locked, 1'b0);
      wr(TI, 16'h0020, 1);
      rd(TI, 16'h0020, 1);
      $display("reset test done");
      print_verdict();
   end

   initial begin
      #4000000;
      failures++;
      $display("FAIL watchdog expired");
      print_verdict();
   end
endmodule : eep_slave_test

bind eep_slave eep_slave_sva #(.WRITE_CYCLES(WRITE_CYCLES)) i_sva (
   .clk_in(clk_in), .resetn_in(resetn_in), .scl_in(scl_in), .sda_in(sda_in),
   .chip_select_strap_hi_in(chip_select_strap_hi_in),
   .chip_select_strap_mid_in(chip_select_strap_mid_in),
   .chip_select_strap_lo_in(chip_select_strap_lo_in),
   .write_protect_input_in(write_protect_input_in), .sda_out(sda_out),
   .sda_oe_out(sda_oe_out), .write_busy_out(write_busy_out), .id_locked_out(id_locked_out));
`default_nettype wire
